// [rtl/gdfm_pkg.sv]
// Purpose: Shared constants for the gate driver fault manager
// Assumes: 40 MHz core clock, 32-bit AHB-Lite register access
// Notes: Times in microseconds, cycle counts derived from the clock rate
package gdfm_pkg;
   localparam int CLK_MHZ = 40;
   localparam int DG_W = 10;
   localparam int NSW = 4;
   localparam int NBR = 2;
   localparam int NCH = 8;
   localparam int DG_US_0 = 1;
   localparam int DG_US_1 = 2;
   localparam int DG_US_2 = 4;
   localparam int DG_US_3 = 8;
   localparam int HW_DG_US = 4;
   localparam logic [DG_W-1:0] HW_DG_CYC = DG_W'(HW_DG_US * CLK_MHZ);

   function automatic logic [DG_W-1:0] dg_cycles(input logic [1:0] code);
      logic [DG_W-1:0] c;
      c = DG_W'(DG_US_0 * CLK_MHZ);
      case (code)
         2'h1: c = DG_W'(DG_US_1 * CLK_MHZ);
         2'h2: c = DG_W'(DG_US_2 * CLK_MHZ);
         2'h3: c = DG_W'(DG_US_3 * CLK_MHZ);
         default: c = DG_W'(DG_US_0 * CLK_MHZ);
      endcase
      return c;
   endfunction : dg_cycles

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SUP = 8'h04;
   localparam logic [7:0] ADDR_OC = 8'h08;
   localparam logic [7:0] ADDR_GF = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   localparam int CTRL_EN = 0;
   localparam int CTRL_CLR = 1;
   localparam int CTRL_DIAG = 2;
   localparam int CTRL_PU = 3;
   localparam int CTRL_PD = 5;
   localparam int SUP_OVMODE = 0;
   localparam int SUP_OVTHR = 2;
   localparam int SUP_OVDG = 4;
   localparam int SUP_UVMODE = 6;
   localparam int SUP_UVTHR = 7;
   localparam int OC_THR = 0;
   localparam int OC_DG = 4;
   localparam int OC_MODE = 6;
   localparam int OC_ISO = 8;
   localparam int OC_PDS = 9;
   localparam int OC_SINK = 13;
   localparam int OC_BRG = 17;
   localparam int GF_MODE = 0;
   localparam int GF_ISO = 2;
   localparam int GF_THR = 3;
   localparam int GF_DRV = 5;
   localparam int ST_FAULT = 0;
   localparam int ST_WARN = 1;
   localparam int ST_OV = 2;
   localparam int ST_UV = 3;
   localparam int ST_OTW = 4;
   localparam int ST_OVERHEAT_SHUTDOWN_FLAG = 5;
   localparam int ST_OC = 6;
   localparam int ST_GF = 10;

   localparam logic [31:0] CTRL_MASK = 32'h0000007d;
   localparam logic [31:0] SUP_MASK = 32'h000001ff;
   localparam logic [31:0] OC_MASK = 32'h0007ffff;
   localparam logic [31:0] GF_MASK = 32'h0000007f;
   localparam logic [31:0] REG_RST = 32'h00000000;

   localparam logic [1:0] MODE_LATCH = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [1:0] MODE_WARN = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h3;
   localparam logic UV_LATCH = 1'b0;
   localparam logic [1:0] BRG_INDEP = 2'h0;
   localparam logic [1:0] BRG_SPLIT = 2'h3;
   localparam logic [2:0] LVL_OFF = 3'h6;
   localparam logic [1:0] PUMP_THR_2V = 2'h1;
endpackage : gdfm_pkg

// [rtl/deglitch_filter.sv]
// Purpose: Qualifies a comparator level held for a programmed cycle count
// Assumes: Input synchronous to ref_clk
// Notes: Output rises only after hold_cycles plus one asserted cycles
`timescale 1ns/1ps
module deglitch_filter (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic level_in,
   input wire logic [gdfm_pkg::DG_W-1:0] hold_cycles,
   output logic qualified_q
);
   import gdfm_pkg::*;
   logic [DG_W-1:0] cnt_q;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= '0;
         qualified_q <= 1'b0;
      end
      else
      begin
         if (!level_in)
            cnt_q <= '0;
         else if (cnt_q < hold_cycles)
            cnt_q <= cnt_q + 1'b1;
         qualified_q <= level_in && (cnt_q >= hold_cycles);
      end
   end

   property p_dg_restart;
      @(posedge ref_clk) disable iff (!rst_b)
      !level_in |=> (cnt_q == '0) && !qualified_q;
   endproperty
   a_dg_restart: assert property (p_dg_restart) else $error("deglitch did not restart");
endmodule : deglitch_filter

// [rtl/gate_driver_fault_manager.sv]
// Purpose: Fault detection, response and offline diagnostics of a gate driver
// Assumes: Comparator inputs synchronous to ref_clk, AHB-Lite register access
// Notes: Registered outputs; a set always beats a clear
// Function
// - Qualified supply overvoltage acts per mode
// - Latched overvoltage holds fault until clear
// - Auto overvoltage releases fault, flag stays
// - Warning overvoltage sets flags, drivers untouched
// - Overvoltage off when disabled or pin variant
// - Pump undervoltage pulls down and faults
// - Latched undervoltage also stops charge pump
// - Auto undervoltage releases fault, flag stays
// - Pin variant: auto recovery, fixed threshold
// - Overcurrent from threshold and deglitch fields
// - Isolation selects all or faulted bridge
// - Latched overcurrent holds fault until clear
// - Cycle mode: next PWM releases fault
// - Overcurrent warning and disabled modes
// - Pin variant fixes overcurrent, top level disables
// - Fault pulldown strength selection
// - Gate fault detection with isolation choice
// - Gate fault modes mirror overcurrent
// - Pin variant fixes gate fault handling
// - Thermal warning sticky flags, not pin variant
// - Thermal shutdown latched, pin variant auto
// - Host diagnostic sequence with node sources
// - Diagnostics show live overcurrent comparator outputs
// - Clear command self-resets, needs condition gone
`timescale 1ns/1ps
module gate_driver_fault_manager (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic pin_config_variant,
   input wire logic [2:0] threshold_multilevel_pin,
   input wire logic sup_ov_cmp,
   input wire logic pump_uv_cmp,
   input wire logic [gdfm_pkg::NSW-1:0] oc_cmp,
   input wire logic [gdfm_pkg::NSW-1:0] gf_cmp,
   input wire logic overheat_warn_cmp,
   input wire logic overheat_sd_cmp,
   input wire logic [gdfm_pkg::NBR-1:0] pwm_in,
   output logic [gdfm_pkg::NBR-1:0] gate_pulldown_q,
   output logic [3:0] pulldown_strength_q,
   output logic pump_disable_q,
   output logic interrupt_out_n_o_q,
   output logic interrupt_out_n_oe_q,
   output logic [gdfm_pkg::NBR-1:0] switch_node_pullup_on_q,
   output logic [gdfm_pkg::NBR-1:0] switch_node_pulldown_on_q,
   output logic [1:0] supply_ov_threshold_q,
   output logic [1:0] pump_uv_threshold_q,
   output logic [3:0] drain_source_threshold_q,
   output logic [1:0] gate_source_threshold_q
);
   import gdfm_pkg::*;

   logic [31:0] ctrl_q, sup_q, oc_q, gf_q, hrdata_q, stat_word, rd_mux;
   logic clr_q, hready_q, ap_valid_q, ap_write_q, ap_word_q;
   logic [7:0] ap_addr_q;
   logic hw, drv_en, diag_en, sup_en, sup_det, uv_det, uv_mode_e;
   logic [1:0] sup_mode, oc_mode_e, gf_mode_e, topo;
   logic iso_oc, iso_gf, topo_ok;
   logic [DG_W-1:0] oc_hold, gf_hold;
   logic sup_flag_q, sup_flt_q, uv_flag_q, uv_flt_q, uv_cpoff_q;
   logic otw_q, overheat_shutdown_flag_q, warn_q, fault_q, fault_any, warn_ev;
   logic [NCH-1:0] ch_cmp, ch_det, ch_flag_q, ch_flt_q, ch_warn;
   logic [NBR-1:0] pwm_prev_q, pwm_rise, br_local;
   logic global_oc, stop_all;

   assign hreadyout = hready_q;
   assign hrdata = hrdata_q;
   assign hresp = 1'b0;

   // Pin variant overrides
   assign hw = pin_config_variant;
   assign drv_en = ctrl_q[CTRL_EN] | hw;
   assign diag_en = ctrl_q[CTRL_DIAG] & ~hw;
   assign sup_mode = sup_q[SUP_OVMODE+:2];
   assign sup_en = !hw && (sup_mode != MODE_OFF);
   assign uv_mode_e = hw ? ~UV_LATCH : sup_q[SUP_UVMODE];
   // fixed cycle mode, top level off
   assign oc_mode_e = hw ? ((threshold_multilevel_pin == LVL_OFF) ? MODE_OFF : MODE_AUTO) : oc_q[OC_MODE+:2];
   assign gf_mode_e = hw ? ((threshold_multilevel_pin == LVL_OFF) ? MODE_OFF : MODE_AUTO) : gf_q[GF_MODE+:2];
   assign oc_hold = hw ? HW_DG_CYC : dg_cycles(oc_q[OC_DG+:2]);
   assign gf_hold = hw ? HW_DG_CYC : dg_cycles(gf_q[GF_DRV+:2]);
   assign topo = oc_q[OC_BRG+:2];
   // isolation only in independent or split topology
   assign topo_ok = (topo == BRG_INDEP) || (topo == BRG_SPLIT);
   assign iso_oc = topo_ok && (hw || oc_q[OC_ISO]);
   assign iso_gf = topo_ok && (hw || gf_q[GF_ISO]);
   assign ch_cmp = {gf_cmp, oc_cmp};
   assign pwm_rise = pwm_in & ~pwm_prev_q;

   deglitch_filter u_sup_dg (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .level_in(sup_ov_cmp & sup_en),
      .hold_cycles(dg_cycles(sup_q[SUP_OVDG+:2])),
      .qualified_q(sup_det)
   );

   deglitch_filter u_uv_dg (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .level_in(pump_uv_cmp),
      .hold_cycles(dg_cycles(sup_q[SUP_OVDG+:2])),
      .qualified_q(uv_det)
   );

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      deglitch_filter u_dg (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .level_in(ch_cmp[c]),
         .hold_cycles(c < NSW ? oc_hold : gf_hold),
         .qualified_q(ch_det[c])
      );
   end

   // AHB-Lite slave; reads take one wait state so a write just before is seen
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_word_q <= 1'b0;
         ap_addr_q <= 8'h00;
         hready_q <= 1'b1;
         hrdata_q <= REG_RST;
      end
      else
      begin
         if (hready)
         begin
            ap_valid_q <= hsel && (htrans == HTRANS_NONSEQ);
            ap_write_q <= hwrite;
            ap_word_q <= (hsize == SIZE_WORD);
            ap_addr_q <= haddr[7:0];
            if (hsel && (htrans == HTRANS_NONSEQ) && !hwrite)
               hready_q <= 1'b0;
         end
         if (!hready_q)
         begin
            hrdata_q <= rd_mux;
            hready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_q <= REG_RST;
         sup_q <= REG_RST;
         oc_q <= REG_RST;
         gf_q <= REG_RST;
         clr_q <= 1'b0;
      end
      else
      begin
         clr_q <= 1'b0;
         if (ap_valid_q && ap_write_q && ap_word_q && hready)
         begin
            case (ap_addr_q)
               ADDR_CTRL:
               begin
                  ctrl_q <= hwdata & CTRL_MASK;
                  clr_q <= hwdata[CTRL_CLR] & ~hw;
               end
               ADDR_SUP: sup_q <= hwdata & SUP_MASK;
               ADDR_OC: oc_q <= hwdata & OC_MASK;
               ADDR_GF: gf_q <= hwdata & GF_MASK;
               default: clr_q <= 1'b0;
            endcase
         end
      end
   end

   always_comb
   begin
      stat_word = REG_RST;
      stat_word[ST_FAULT] = fault_q;
      stat_word[ST_WARN] = warn_q;
      stat_word[ST_OV] = sup_flag_q;
      stat_word[ST_UV] = uv_flag_q;
      stat_word[ST_OTW] = otw_q;
      stat_word[ST_OVERHEAT_SHUTDOWN_FLAG] = overheat_shutdown_flag_q;
      stat_word[ST_OC+:NSW] = diag_en ? oc_cmp : ch_flag_q[NSW-1:0];
      stat_word[ST_GF+:NSW] = ch_flag_q[NCH-1:NSW];
      case (ap_addr_q)
         ADDR_CTRL: rd_mux = ctrl_q;
         ADDR_SUP: rd_mux = sup_q;
         ADDR_OC: rd_mux = oc_q;
         ADDR_GF: rd_mux = gf_q;
         ADDR_STAT: rd_mux = stat_word;
         default: rd_mux = REG_RST;
      endcase
   end

   // Supply overvoltage; a set always wins over a clear
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sup_flag_q <= 1'b0;
         sup_flt_q <= 1'b0;
      end
      else
      begin
         if (sup_det && sup_en)
            sup_flag_q <= 1'b1;
         else if (clr_q)
            sup_flag_q <= 1'b0;
         if (sup_det && (sup_mode == MODE_LATCH || sup_mode == MODE_AUTO))
            sup_flt_q <= 1'b1;
         else if (clr_q || sup_mode != MODE_LATCH)
            sup_flt_q <= 1'b0;
      end
   end

   // Pump undervoltage
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         uv_flag_q <= 1'b0;
         uv_flt_q <= 1'b0;
         uv_cpoff_q <= 1'b0;
      end
      else
      begin
         if (uv_det)
            uv_flag_q <= 1'b1;
         else if (clr_q)
            uv_flag_q <= 1'b0;
         if (uv_det)
            uv_flt_q <= 1'b1;
         else if (clr_q || uv_mode_e != UV_LATCH)
            uv_flt_q <= 1'b0;
         if (uv_det && uv_mode_e == UV_LATCH)
            uv_cpoff_q <= 1'b1;
         else if (clr_q || uv_mode_e != UV_LATCH)
            uv_cpoff_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ch_flag_q <= '0;
         ch_flt_q <= '0;
         pwm_prev_q <= '0;
      end
      else
      begin
         pwm_prev_q <= pwm_in;
         for (int c = 0; c < NCH; c++)
         begin
            if (ch_det[c] && ((c < NSW ? oc_mode_e : gf_mode_e) != MODE_OFF))
               ch_flag_q[c] <= 1'b1;
            else if (clr_q)
               ch_flag_q[c] <= 1'b0;
            if (ch_det[c] && ((c < NSW ? oc_mode_e : gf_mode_e) inside {MODE_LATCH, MODE_AUTO}))
               ch_flt_q[c] <= 1'b1;
            else if (clr_q || ((c < NSW ? oc_mode_e : gf_mode_e) == MODE_AUTO && pwm_rise[(c % NSW) / 2]))
               ch_flt_q[c] <= 1'b0;
         end
      end
   end

   always_comb
   begin
      for (int c = 0; c < NCH; c++)
         ch_warn[c] = ch_det[c] && ((c < NSW ? oc_mode_e : gf_mode_e) == MODE_WARN);
   end

   always_comb
   begin
      for (int b = 0; b < NBR; b++)
         br_local[b] = ((|ch_flt_q[2*b+:2]) && iso_oc) || ((|ch_flt_q[NSW+2*b+:2]) && iso_gf);
   end
   assign global_oc = ((|ch_flt_q[NSW-1:0]) && !iso_oc) || ((|ch_flt_q[NCH-1:NSW]) && !iso_gf);
   assign stop_all = sup_flt_q || uv_flt_q || overheat_shutdown_flag_q || global_oc;
   assign fault_any = sup_flt_q || uv_flt_q || overheat_shutdown_flag_q || (|ch_flt_q);
   assign warn_ev = (sup_det && sup_mode == MODE_WARN) || (overheat_warn_cmp && !hw) || (|ch_warn);

   // Thermal and summary flags
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         otw_q <= 1'b0;
         overheat_shutdown_flag_q <= 1'b0;
         warn_q <= 1'b0;
         fault_q <= 1'b0;
      end
      else
      begin
         if (overheat_warn_cmp && !hw)
            otw_q <= 1'b1;
         else if (clr_q)
            otw_q <= 1'b0;
         if (overheat_sd_cmp)
            overheat_shutdown_flag_q <= 1'b1;
         else if (clr_q || hw)
            overheat_shutdown_flag_q <= 1'b0;
         if (warn_ev)
            warn_q <= 1'b1;
         else if (clr_q)
            warn_q <= 1'b0;
         fault_q <= fault_any;
      end
   end

   // Outputs, all registered
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gate_pulldown_q <= '1;
         pulldown_strength_q <= 4'h0;
         pump_disable_q <= 1'b0;
         interrupt_out_n_o_q <= 1'b0;
         interrupt_out_n_oe_q <= 1'b0;
         switch_node_pullup_on_q <= '0;
         switch_node_pulldown_on_q <= '0;
         supply_ov_threshold_q <= 2'h0;
         pump_uv_threshold_q <= 2'h0;
         drain_source_threshold_q <= 4'h0;
         gate_source_threshold_q <= 2'h0;
      end
      else
      begin
         for (int b = 0; b < NBR; b++)
            gate_pulldown_q[b] <= !drv_en || stop_all || br_local[b];
         pulldown_strength_q <= ((|ch_flt_q[NSW-1:0]) && !hw) ? oc_q[OC_PDS+:4] : oc_q[OC_SINK+:4];
         pump_disable_q <= uv_cpoff_q || overheat_shutdown_flag_q;
         interrupt_out_n_o_q <= 1'b0;
         interrupt_out_n_oe_q <= fault_any;
         switch_node_pullup_on_q <= diag_en ? ctrl_q[CTRL_PU+:NBR] : '0;
         switch_node_pulldown_on_q <= diag_en ? ctrl_q[CTRL_PD+:NBR] : '0;
         supply_ov_threshold_q <= sup_q[SUP_OVTHR+:2];
         pump_uv_threshold_q <= hw ? PUMP_THR_2V : sup_q[SUP_UVTHR+:2];
         drain_source_threshold_q <= oc_q[OC_THR+:4];
         gate_source_threshold_q <= gf_q[GF_THR+:2];
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   property p_clr_self;
      clr_q |=> !clr_q;
   endproperty
   a_clr_self: assert property (p_clr_self) else $error("clear stuck");

   property p_sup_lat;
      sup_flt_q && sup_mode == MODE_LATCH && !clr_q |=> sup_flt_q;
   endproperty
   a_sup_lat: assert property (p_sup_lat) else $error("latched fault lost");

   property p_sup_auto;
      sup_flt_q && sup_mode == MODE_AUTO && !sup_det |=> !sup_flt_q ##1 (!interrupt_out_n_oe_q || $past(fault_any));
   endproperty
   a_sup_auto: assert property (p_sup_auto) else $error("auto recovery failed");

   property p_sup_warn;
      sup_det && sup_mode == MODE_WARN |=> sup_flag_q && warn_q;
   endproperty
   a_sup_warn: assert property (p_sup_warn) else $error("warning not set");

   property p_sup_off;
      !sup_en && !sup_flag_q |=> !sup_flag_q;
   endproperty
   a_sup_off: assert property (p_sup_off) else $error("disabled monitor reported");

   property p_uv_cp;
      uv_det && uv_mode_e == UV_LATCH |=> ##1 pump_disable_q;
   endproperty
   a_uv_cp: assert property (p_uv_cp) else $error("pump not disabled");

   property p_pin;
      fault_any |=> interrupt_out_n_oe_q && !interrupt_out_n_o_q;
   endproperty
   a_pin: assert property (p_pin) else $error("fault pin not driven");

   property p_cyc;
      ch_flt_q[2] && !ch_det[2] && oc_mode_e == MODE_AUTO && pwm_rise[1] && !clr_q |=> !ch_flt_q[2] && ch_flag_q[2];
   endproperty
   a_cyc: assert property (p_cyc) else $error("cycle release wrong");

   property p_diag;
      diag_en |-> stat_word[ST_OC+:NSW] == oc_cmp;
   endproperty
   a_diag: assert property (p_diag) else $error("diag status not live");

   property p_overheat_shutdown_flag;
      overheat_sd_cmp |=> ##1 pump_disable_q && (&gate_pulldown_q);
   endproperty
   a_overheat_shutdown_flag: assert property (p_overheat_shutdown_flag) else $error("shutdown response missing");

   c_sup_lat: cover property (sup_det && sup_mode == MODE_LATCH ##1 sup_flt_q);
   c_cyc: cover property (ch_flt_q[2] ##1 !ch_flt_q[2] && ch_flag_q[2]);
   c_diag: cover property (diag_en && !hready_q);
endmodule : gate_driver_fault_manager

// [dv/host_model.sv]
// Purpose: Host microcontroller model, AHB-Lite master
// Assumes: Single word transfers to the one slave
// Notes: Every wait is bounded; ok drops on timeout
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   import gdfm_pkg::*;
   initial
   begin
      hsel = 1'b0;
      haddr = '0;
      htrans = '0;
      hwrite = 1'b0;
      hsize = SIZE_WORD;
      hwdata = '0;
   end
   // Bounded wait for hready high at an edge
   task automatic rdy(inout logic ok);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
         ok = 1'b0;
   endtask : rdy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic ok);
      ok = 1'b1;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy(ok);
      // Released address must not look valid
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~haddr;
      hwdata <= d;
      rdy(ok);
      r = hrdata;
   endtask : xfer
endmodule : host_model

// [dv/testbench.sv]
// Purpose: Self-checking bench of the fault manager
// Assumes: 40 MHz clock, host model on the register bus
// Notes: Deglitch code 0 everywhere, so 40 cycle hold, 41 to qualify
`timescale 1ns/1ps
module testbench;
   import gdfm_pkg::*;
   logic ref_clk, hsel, hwrite, hreadyout, hresp, pump_disable_q, interrupt_out_n_oe_q, interrupt_out_n_o_q;
   logic rst_b = 1'b0, pin_config_variant = 1'b0, sup_ov_cmp = 1'b0, pump_uv_cmp = 1'b0;
   logic overheat_warn_cmp = 1'b0, overheat_sd_cmp = 1'b0;
   logic [2:0] threshold_multilevel_pin = 3'h1, hsize;
   logic [NSW-1:0] oc_cmp = '0, gf_cmp = '0;
   logic [NBR-1:0] pwm_in = '0, gate_pulldown_q, switch_node_pullup_on_q, switch_node_pulldown_on_q;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, pump_uv_threshold_q, supply_ov_threshold_q, gate_source_threshold_q;
   logic [3:0] pulldown_strength_q, drain_source_threshold_q;
   int bad_count = 0, cmp_count = 0;
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   host_model u_host (.ref_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
   gate_driver_fault_manager u_dut (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_config_variant, .threshold_multilevel_pin,
      .sup_ov_cmp, .pump_uv_cmp, .oc_cmp, .gf_cmp, .overheat_warn_cmp, .overheat_sd_cmp, .pwm_in,
      .gate_pulldown_q, .pulldown_strength_q, .pump_disable_q, .interrupt_out_n_o_q,
      .interrupt_out_n_oe_q, .switch_node_pullup_on_q, .switch_node_pulldown_on_q,
      .supply_ov_threshold_q, .pump_uv_threshold_q, .drain_source_threshold_q, .gate_source_threshold_q);
   task automatic results();
      $display("Compared %0d, mismatched %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      logic ok;
      u_host.xfer(w, a, d, r, ok);
      if (ok !== 1'b1)
      begin
         bad_count++;
         results();
      end
   endtask : bus
   // Short settle so registered outputs can be sampled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      cyc(2);
   endtask : wr
   task automatic rchk(input string nm, input logic [31:0] e, input logic [7:0] a);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask : rchk
   task automatic wait_oe(input logic e);
      int n;
      for (n = 0; n < 500 && interrupt_out_n_oe_q !== e; n++) @(posedge ref_clk);
      chk("fault_oe", 32'(e), 32'(interrupt_out_n_oe_q));
      if (interrupt_out_n_oe_q !== e)
         results();
   endtask : wait_oe
   task automatic clr();
      wr(ADDR_CTRL, 32'h3);
      cyc(3);
   endtask : clr
   task automatic t_regs();
      logic [7:0] ad [5] = '{ADDR_CTRL, ADDR_SUP, ADDR_OC, ADDR_GF, ADDR_STAT};
      foreach (ad[i]) rchk("reg_rst", REG_RST, ad[i]);
      wr(ADDR_SUP, 32'hffffffff);
      rchk("sup_mask", SUP_MASK, ADDR_SUP);
      chk("ov_thr", 32'h3, 32'(supply_ov_threshold_q));
      chk("uv_thr", 32'h3, 32'(pump_uv_threshold_q));
      wr(ADDR_STAT, 32'hffffffff);
      rchk("stat_ro", REG_RST, ADDR_STAT);
      rchk("unmapped", 32'h0, 8'h20);
      wr(ADDR_CTRL, 32'h3);
      rchk("clr_self", 32'h1, ADDR_CTRL);
      chk("drv_on", 32'h0, 32'(gate_pulldown_q));
      chk("hresp", 32'h0, 32'(hresp));
      $display("regs done");
   endtask : t_regs
   task automatic t_ov();
      logic [1:0] m;
      logic [31:0] s;
      for (int i = 0; i < 4; i++)
      begin
         m = 2'(i);
         wr(ADDR_SUP, 32'(m));
         sup_ov_cmp <= 1'b1;
         cyc(30);
         sup_ov_cmp <= 1'b0;
         rchk("ov_glitch", 32'h0, ADDR_STAT);
         sup_ov_cmp <= 1'b1;
         cyc(60);
         s = (m == MODE_WARN) ? 32'h6 : (m == MODE_OFF) ? 32'h0 : 32'h5;
         rchk("ov_stat", s, ADDR_STAT);
         chk("ov_pd", {30'h0, {2{m < MODE_WARN}}}, 32'(gate_pulldown_q));
         sup_ov_cmp <= 1'b0;
         cyc(5);
         rchk("ov_after", (m == MODE_AUTO) ? 32'h4 : s, ADDR_STAT);
         chk("ov_oe", 32'(m == MODE_LATCH), 32'(interrupt_out_n_oe_q));
         clr();
         rchk("ov_clr", 32'h0, ADDR_STAT);
      end
      $display("ov done");
   endtask : t_ov
   task automatic t_uv();
      for (int j = 0; j < 2; j++)
      begin
         wr(ADDR_SUP, 32'h3 | (32'h40 * j));
         pump_uv_cmp <= 1'b1;
         cyc(60);
         rchk("uv_stat", 32'h9, ADDR_STAT);
         chk("uv_pd", 32'h3, 32'(gate_pulldown_q));
         pump_uv_cmp <= 1'b0;
         cyc(5);
         rchk("uv_after", j ? 32'h8 : 32'h9, ADDR_STAT);
         chk("uv_pump", 32'(j == 0), 32'(pump_disable_q));
         clr();
         chk("uv_pump_clr", 32'h0, 32'(pump_disable_q));
      end
      $display("uv done");
   endtask : t_uv
   task automatic t_oc();
      wr(ADDR_OC, 32'h7545);
      chk("oc_thr", 32'h5, 32'(drain_source_threshold_q));
      chk("sink", 32'h3, 32'(pulldown_strength_q));
      oc_cmp <= 4'b0100;
      wait_oe(1'b1);
      cyc(3);
      chk("oc_iso", 32'h2, 32'(gate_pulldown_q));
      chk("oc_pds", 32'ha, 32'(pulldown_strength_q));
      chk("int_lvl", 32'h0, 32'(interrupt_out_n_o_q));
      oc_cmp <= 4'h0;
      cyc(10);
      wait_oe(1'b1);
      pwm_in <= 2'b10;
      wait_oe(1'b0);
      rchk("oc_cyc", 32'h100, ADDR_STAT);
      pwm_in <= 2'b00;
      clr();
      wr(ADDR_OC, 32'h6005);
      oc_cmp <= 4'b0001;
      wait_oe(1'b1);
      cyc(3);
      chk("oc_all", 32'h3, 32'(gate_pulldown_q));
      oc_cmp <= 4'h0;
      pwm_in <= 2'b01;
      cyc(10);
      wait_oe(1'b1);
      pwm_in <= 2'b00;
      clr();
      wait_oe(1'b0);
      wr(ADDR_OC, 32'h80);
      oc_cmp <= 4'b1000;
      cyc(60);
      rchk("oc_warn", 32'h202, ADDR_STAT);
      wait_oe(1'b0);
      oc_cmp <= 4'h0;
      clr();
      $display("oc done");
   endtask : t_oc
   task automatic t_gf();
      wr(ADDR_GF, 32'h1d);
      chk("gs_thr", 32'h3, 32'(gate_source_threshold_q));
      gf_cmp <= 4'b0010;
      wait_oe(1'b1);
      cyc(3);
      chk("gf_iso", 32'h1, 32'(gate_pulldown_q));
      rchk("gf_stat", 32'h801, ADDR_STAT);
      gf_cmp <= 4'h0;
      cyc(5);
      pwm_in <= 2'b01;
      wait_oe(1'b0);
      rchk("gf_flag", 32'h800, ADDR_STAT);
      pwm_in <= 2'b00;
      clr();
      $display("gf done");
   endtask : t_gf
   task automatic t_th();
      overheat_warn_cmp <= 1'b1;
      cyc(60);
      overheat_warn_cmp <= 1'b0;
      cyc(5);
      rchk("otw", 32'h12, ADDR_STAT);
      clr();
      overheat_sd_cmp <= 1'b1;
      wait_oe(1'b1);
      cyc(3);
      chk("overheat_shutdown_flag_pump", 32'h1, 32'(pump_disable_q));
      overheat_sd_cmp <= 1'b0;
      cyc(5);
      rchk("overheat_shutdown_flag", 32'h21, ADDR_STAT);
      clr();
      wait_oe(1'b0);
      $display("thermal done");
   endtask : t_th
   task automatic t_diag();
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CTRL, 32'h4c);
      chk("pu", 32'h1, 32'(switch_node_pullup_on_q));
      chk("pdn", 32'h2, 32'(switch_node_pulldown_on_q));
      oc_cmp <= 4'b0101;
      cyc(2);
      rchk("live0", 32'h140, ADDR_STAT);
      oc_cmp <= 4'b1010;
      cyc(2);
      rchk("live1", 32'h280, ADDR_STAT);
      oc_cmp <= 4'h0;
      wr(ADDR_CTRL, 32'h4);
      chk("src_off", 32'h0, {28'h0, switch_node_pullup_on_q, switch_node_pulldown_on_q});
      wr(ADDR_CTRL, 32'h1);
      chk("drv_back", 32'h0, 32'(gate_pulldown_q));
      $display("diag done");
   endtask : t_diag
   task automatic t_pin();
      wr(ADDR_SUP, 32'h0);
      pin_config_variant <= 1'b1;
      threshold_multilevel_pin <= LVL_OFF;
      sup_ov_cmp <= 1'b1;
      oc_cmp <= 4'hf;
      gf_cmp <= 4'hf;
      overheat_warn_cmp <= 1'b1;
      cyc(400);
      wait_oe(1'b0);
      rchk("pin_stat", 32'h0, ADDR_STAT);
      chk("pin_uvthr", 32'(PUMP_THR_2V), 32'(pump_uv_threshold_q));
      overheat_sd_cmp <= 1'b1;
      wait_oe(1'b1);
      overheat_sd_cmp <= 1'b0;
      wait_oe(1'b0);
      $display("pin done");
   endtask : t_pin
   initial
   begin
      repeat (3) @(posedge ref_clk);
      chk("rst_pd", 32'h3, 32'(gate_pulldown_q));
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_ov();
      t_uv();
      t_oc();
      t_gf();
      t_th();
      t_diag();
      t_pin();
      results();
   end
endmodule : testbench
